// ### verilog/spi_status_regs.vh
// Constants of the status register bank: word addresses, frame layout, bit positions.
// Included by the status bank top module only; defines only.
`ifndef SPI_STATUS_REGS_VH
`define SPI_STATUS_REGS_VH

// Frame layout
`define FRAME_W 32
`define FRAME_ADDR_LSB 0
`define FRAME_ADDR_MSB 6
`define FRAME_MODE_BIT 7
`define FRAME_DATA_LSB 8
`define FRAME_DATA_MSB 23
`define FRAME_CRC_LSB 24
`define FRAME_CRC_MSB 31

// Word addresses (7 bit)
`define ADDR_SUPPLY_FAIL 7'h40
`define ADDR_THERMAL 7'h41
`define ADDR_DEVICE_INFO 7'h42
`define ADDR_WAKE_SOURCE 7'h44
`define ADDR_WAKE_LEVEL 7'h45
`define ADDR_GEN_BRIDGE 7'h50
`define ADDR_DELAY_REG 7'h51
`define ADDR_DS_OV 7'h52
`define ADDR_EFF_DELAY1 7'h53
`define ADDR_EFF_DELAY2 7'h54
`define ADDR_EFF_DELAY3 7'h55
`define ADDR_EDGE_TIME1 7'h57
`define ADDR_EDGE_TIME2 7'h58
`define ADDR_EDGE_TIME3 7'h59
`define ADDR_FAMILY_ID 7'h70

// Supply fail status bits
`define SUP_POR_BIT 15
`define SUP_RES_MASK 16'h6000
`define SUP_PUMP_OT_BIT 12
`define SUP_FS_UV_BIT 11
`define SUP_BATT_UV_BIT 6
`define SUP_BATT_OV_BIT 5
`define SUP_PUMP_UV_BIT 4
`define SUP_REG_SC_BIT 3
`define SUP_REG_UV_BIT 2
`define SUP_REG_OV_BIT 1
`define SUP_REG_WARN_BIT 0

// Reset values
`define STAT_RESET 16'h0000
`define SUP_POR_VALUE 16'h8000

// Consecutive regulator undervoltage count for fail-safe entry
`define FS_UV_COUNT 3'h4
`define WORD_ZERO 16'h0000

`endif

// ### verilog/status_word.v
// One latched status word: sticky flags, word-wise clear, set wins over clear.
// Assumes event inputs are synchronous one-or-more-cycle levels on clk.
`timescale 1ns/1ps
`default_nettype none
module status_word #(
  parameter W = 16,
  parameter [W-1:0] RESET_VALUE = {W{1'b0}},
  parameter [W-1:0] VALID_MASK = {W{1'b1}}
) (
  input wire clk,
  input wire rst_b,
  input wire soft_reset,
  input wire clear,
  input wire [W-1:0] events,
  output wire [W-1:0] value
);
  reg [W-1:0] flags_q;
  reg [W-1:0] flags_d;

  // Next value: clear the word, then new events set their flags
  always @*
  begin
    flags_d = flags_q;
    if (clear)
      flags_d = {W{1'b0}}; // R3
    flags_d = flags_d | events; // R17 R5
  end

  // Flags latch; only clear or reset drops them
  always @(posedge clk)
  begin
    if (!rst_b)
      flags_q <= RESET_VALUE;
    else if (soft_reset)
      flags_q <= {W{1'b0}};
    else
      flags_q <= flags_d & VALID_MASK;
  end

  assign value = flags_q & VALID_MASK;
endmodule
`default_nettype wire

// ### verilog/spi_status_register_bank.v
// Status register bank behind the 32-bit SPI frame of a motor gate driver.
// Assumes a decoded frame arrives as a one-cycle strobe with a checked CRC.
// Overview of operation
// R1: A frame is 32 bits: 7-bit address, mode bit, two data bytes, CRC.
// R2: Mode bit 0 returns the addressed word unchanged.
// R3: Mode bit 1 clears the whole addressed word; payload ignored.
// R4: Status data travels in frame bits 8 to 23.
// R5: Flags latch until the master clears them.
// R6: Device status words at 0x40, 0x41, 0x42, 0x44, 0x45.
// R7: Bridge status words at 0x50 to 0x55 and 0x57 to 0x59.
// R8: Address 0x70 returns a read-only family and product word.
// R9: Supply bits 14 and 13 always read zero.
// R10: Bit 12 latches charge pump overtemperature.
// R11: Bit 11 latches fail-safe entry on fourth consecutive regulator undervoltage.
// R12: Battery under/overvoltage bits 6 and 5 set only while regulator enabled.
// R13: Bit 4 latches charge pump undervoltage.
// R14: Bit 3 latches regulator output short to ground.
// R15: Power-on flag reads 1 after power-on reset, 0 after soft reset.
// R16: Bits 2, 1, 0 latch regulator undervoltage, overvoltage, prewarning.
// R17: An event in the clear cycle keeps its flag set.
`timescale 1ns/1ps
`default_nettype none
`include "spi_status_regs.vh"
module spi_status_register_bank #(
  parameter W = 16,
  parameter [15:0] FAMILY_ID = 16'h5a01 // Arbitrary identification value
) (
  input wire clk,
  input wire rst_b,
  input wire soft_reset,
  input wire frame_valid,
  input wire [31:0] frame_in,
  output reg [31:0] frame_out,
  output reg frame_out_valid,
  output reg addr_error,
  input wire main_regulator_output,
  input wire pump_overtemp_flag,
  input wire regulator_uv_reset_event,
  input wire battery_undervoltage_flag,
  input wire battery_overvoltage_flag,
  input wire pump_undervoltage_flag,
  input wire regulator_short_flag,
  input wire regulator_undervoltage_flag,
  input wire regulator_overvoltage_flag,
  input wire regulator_prewarning_flag,
  input wire [W-1:0] supply_other_events,
  input wire [W-1:0] thermal_events,
  input wire [W-1:0] device_info_events,
  input wire [W-1:0] wake_source_events,
  input wire [W-1:0] wake_level_events,
  input wire [W-1:0] gen_bridge_events,
  input wire [W-1:0] delay_reg_events,
  input wire [W-1:0] ds_ov_events,
  input wire [W-1:0] eff_delay1_events,
  input wire [W-1:0] eff_delay2_events,
  input wire [W-1:0] eff_delay3_events,
  input wire [W-1:0] edge_time1_events,
  input wire [W-1:0] edge_time2_events,
  input wire [W-1:0] edge_time3_events
);
  // Word indices of the clearable status words
  localparam [3:0] IDX_SUPPLY = 4'h0;
  localparam [3:0] IDX_THERMAL = 4'h1;
  localparam [3:0] IDX_DEVICE_INFO = 4'h2;
  localparam [3:0] IDX_WAKE_SOURCE = 4'h3;
  localparam [3:0] IDX_WAKE_LEVEL = 4'h4;
  localparam [3:0] IDX_GEN_BRIDGE = 4'h5;
  localparam [3:0] IDX_DELAY_REG = 4'h6;
  localparam [3:0] IDX_DS_OV = 4'h7;
  localparam [3:0] IDX_EFF_DELAY1 = 4'h8;
  localparam [3:0] IDX_EFF_DELAY2 = 4'h9;
  localparam [3:0] IDX_EFF_DELAY3 = 4'ha;
  localparam [3:0] IDX_EDGE_TIME1 = 4'hb;
  localparam [3:0] IDX_EDGE_TIME2 = 4'hc;
  localparam [3:0] IDX_EDGE_TIME3 = 4'hd;
  localparam [3:0] IDX_NONE = 4'hf;
  // Mask of a word without reserved bits
  localparam [W-1:0] ALL_BITS = {W{1'b1}};

  // Index of the clearable word for a given address
  function [3:0] word_index;
    input [6:0] a;
    begin
      case (a) // R6 R7
        `ADDR_SUPPLY_FAIL: word_index = IDX_SUPPLY;
        `ADDR_THERMAL: word_index = IDX_THERMAL;
        `ADDR_DEVICE_INFO: word_index = IDX_DEVICE_INFO;
        `ADDR_WAKE_SOURCE: word_index = IDX_WAKE_SOURCE;
        `ADDR_WAKE_LEVEL: word_index = IDX_WAKE_LEVEL;
        `ADDR_GEN_BRIDGE: word_index = IDX_GEN_BRIDGE;
        `ADDR_DELAY_REG: word_index = IDX_DELAY_REG;
        `ADDR_DS_OV: word_index = IDX_DS_OV;
        `ADDR_EFF_DELAY1: word_index = IDX_EFF_DELAY1;
        `ADDR_EFF_DELAY2: word_index = IDX_EFF_DELAY2;
        `ADDR_EFF_DELAY3: word_index = IDX_EFF_DELAY3;
        `ADDR_EDGE_TIME1: word_index = IDX_EDGE_TIME1;
        `ADDR_EDGE_TIME2: word_index = IDX_EDGE_TIME2;
        `ADDR_EDGE_TIME3: word_index = IDX_EDGE_TIME3;
        default: word_index = IDX_NONE;
      endcase
    end
  endfunction

  wire [6:0] addr = frame_in[`FRAME_ADDR_MSB:`FRAME_ADDR_LSB]; // R1
  wire clear_mode = frame_in[`FRAME_MODE_BIT];
  wire [3:0] idx = word_index(addr);
  wire is_id = (addr == `ADDR_FAMILY_ID);

  // Fail-safe counter of consecutive regulator undervoltage resets
  reg [2:0] uv_count_q;
  reg [2:0] uv_count_d;
  reg fs_event;
  always @*
  begin
    uv_count_d = uv_count_q;
    fs_event = 1'b0;
    if (regulator_uv_reset_event)
    begin
      if (uv_count_q == `FS_UV_COUNT - 3'h1)
      begin
        fs_event = 1'b1; // R11
        uv_count_d = 3'h0;
      end
      else
        uv_count_d = uv_count_q + 3'h1;
    end
    else if (main_regulator_output && !regulator_undervoltage_flag)
      uv_count_d = 3'h0;
  end

  always @(posedge clk)
  begin
    if (!rst_b)
      uv_count_q <= 3'h0;
    else if (soft_reset)
      uv_count_q <= 3'h0;
    else
      uv_count_q <= uv_count_d;
  end

  // Supply fail event vector
  reg [W-1:0] sup_events;
  always @*
  begin
    sup_events = supply_other_events & ~`SUP_RES_MASK;
    sup_events[`SUP_POR_BIT] = 1'b0;
    sup_events[`SUP_PUMP_OT_BIT] = pump_overtemp_flag; // R10
    sup_events[`SUP_FS_UV_BIT] = fs_event; // R11
    sup_events[`SUP_BATT_UV_BIT] = battery_undervoltage_flag & main_regulator_output; // R12
    sup_events[`SUP_BATT_OV_BIT] = battery_overvoltage_flag & main_regulator_output; // R12
    sup_events[`SUP_PUMP_UV_BIT] = pump_undervoltage_flag; // R13
    sup_events[`SUP_REG_SC_BIT] = regulator_short_flag; // R14
    sup_events[`SUP_REG_UV_BIT] = regulator_undervoltage_flag; // R16
    sup_events[`SUP_REG_OV_BIT] = regulator_overvoltage_flag; // R16
    sup_events[`SUP_REG_WARN_BIT] = regulator_prewarning_flag; // R16
  end

  // Frame strobe that clears the addressed word
  wire clear_hit = frame_valid & clear_mode;

  // Current content of each status word
  wire [W-1:0] supply_value;
  wire [W-1:0] thermal_value;
  wire [W-1:0] device_info_value;
  wire [W-1:0] wake_source_value;
  wire [W-1:0] wake_level_value;
  wire [W-1:0] gen_bridge_value;
  wire [W-1:0] delay_reg_value;
  wire [W-1:0] ds_ov_value;
  wire [W-1:0] eff_delay1_value;
  wire [W-1:0] eff_delay2_value;
  wire [W-1:0] eff_delay3_value;
  wire [W-1:0] edge_time1_value;
  wire [W-1:0] edge_time2_value;
  wire [W-1:0] edge_time3_value;

  // Supply word: power-on flag set at reset, reserved bits held at zero
  status_word #(.W(W), .RESET_VALUE(`SUP_POR_VALUE), .VALID_MASK(~`SUP_RES_MASK)) u_supply ( // R15 R9
    .clk(clk), .rst_b(rst_b), .soft_reset(soft_reset), // R15
    .clear(clear_hit && (idx == IDX_SUPPLY)), .events(sup_events), // R3
    .value(supply_value));

  // Thermal protection word
  status_word #(.W(W), .RESET_VALUE(`STAT_RESET), .VALID_MASK(ALL_BITS)) u_thermal (
    .clk(clk), .rst_b(rst_b), .soft_reset(soft_reset), // R15
    .clear(clear_hit && (idx == IDX_THERMAL)), .events(thermal_events), // R3
    .value(thermal_value));

  // Device information word
  status_word #(.W(W), .RESET_VALUE(`STAT_RESET), .VALID_MASK(ALL_BITS)) u_device_info (
    .clk(clk), .rst_b(rst_b), .soft_reset(soft_reset), // R15
    .clear(clear_hit && (idx == IDX_DEVICE_INFO)), .events(device_info_events), // R3
    .value(device_info_value));

  // Wake source word
  status_word #(.W(W), .RESET_VALUE(`STAT_RESET), .VALID_MASK(ALL_BITS)) u_wake_source (
    .clk(clk), .rst_b(rst_b), .soft_reset(soft_reset), // R15
    .clear(clear_hit && (idx == IDX_WAKE_SOURCE)), .events(wake_source_events), // R3
    .value(wake_source_value));

  // Wake input level word
  status_word #(.W(W), .RESET_VALUE(`STAT_RESET), .VALID_MASK(ALL_BITS)) u_wake_level (
    .clk(clk), .rst_b(rst_b), .soft_reset(soft_reset), // R15
    .clear(clear_hit && (idx == IDX_WAKE_LEVEL)), .events(wake_level_events), // R3
    .value(wake_level_value));

  // General bridge word
  status_word #(.W(W), .RESET_VALUE(`STAT_RESET), .VALID_MASK(ALL_BITS)) u_gen_bridge (
    .clk(clk), .rst_b(rst_b), .soft_reset(soft_reset), // R15
    .clear(clear_hit && (idx == IDX_GEN_BRIDGE)), .events(gen_bridge_events), // R3
    .value(gen_bridge_value));

  // Delay regulation word
  status_word #(.W(W), .RESET_VALUE(`STAT_RESET), .VALID_MASK(ALL_BITS)) u_delay_reg (
    .clk(clk), .rst_b(rst_b), .soft_reset(soft_reset), // R15
    .clear(clear_hit && (idx == IDX_DELAY_REG)), .events(delay_reg_events), // R3
    .value(delay_reg_value));

  // Drain-source overvoltage word
  status_word #(.W(W), .RESET_VALUE(`STAT_RESET), .VALID_MASK(ALL_BITS)) u_ds_ov (
    .clk(clk), .rst_b(rst_b), .soft_reset(soft_reset), // R15
    .clear(clear_hit && (idx == IDX_DS_OV)), .events(ds_ov_events), // R3
    .value(ds_ov_value));

  // Effective delay word, bridge 1
  status_word #(.W(W), .RESET_VALUE(`STAT_RESET), .VALID_MASK(ALL_BITS)) u_eff_delay1 (
    .clk(clk), .rst_b(rst_b), .soft_reset(soft_reset), // R15
    .clear(clear_hit && (idx == IDX_EFF_DELAY1)), .events(eff_delay1_events), // R3
    .value(eff_delay1_value));

  // Effective delay word, bridge 2
  status_word #(.W(W), .RESET_VALUE(`STAT_RESET), .VALID_MASK(ALL_BITS)) u_eff_delay2 (
    .clk(clk), .rst_b(rst_b), .soft_reset(soft_reset), // R15
    .clear(clear_hit && (idx == IDX_EFF_DELAY2)), .events(eff_delay2_events), // R3
    .value(eff_delay2_value));

  // Effective delay word, bridge 3
  status_word #(.W(W), .RESET_VALUE(`STAT_RESET), .VALID_MASK(ALL_BITS)) u_eff_delay3 (
    .clk(clk), .rst_b(rst_b), .soft_reset(soft_reset), // R15
    .clear(clear_hit && (idx == IDX_EFF_DELAY3)), .events(eff_delay3_events), // R3
    .value(eff_delay3_value));

  // Edge time word, bridge 1
  status_word #(.W(W), .RESET_VALUE(`STAT_RESET), .VALID_MASK(ALL_BITS)) u_edge_time1 (
    .clk(clk), .rst_b(rst_b), .soft_reset(soft_reset), // R15
    .clear(clear_hit && (idx == IDX_EDGE_TIME1)), .events(edge_time1_events), // R3
    .value(edge_time1_value));

  // Edge time word, bridge 2
  status_word #(.W(W), .RESET_VALUE(`STAT_RESET), .VALID_MASK(ALL_BITS)) u_edge_time2 (
    .clk(clk), .rst_b(rst_b), .soft_reset(soft_reset), // R15
    .clear(clear_hit && (idx == IDX_EDGE_TIME2)), .events(edge_time2_events), // R3
    .value(edge_time2_value));

  // Edge time word, bridge 3
  status_word #(.W(W), .RESET_VALUE(`STAT_RESET), .VALID_MASK(ALL_BITS)) u_edge_time3 (
    .clk(clk), .rst_b(rst_b), .soft_reset(soft_reset), // R15
    .clear(clear_hit && (idx == IDX_EDGE_TIME3)), .events(edge_time3_events), // R3
    .value(edge_time3_value));

  // Word read out before any clear of the same frame
  reg [W-1:0] read_word;
  always @*
  begin
    case (idx) // R2
      IDX_SUPPLY: read_word = supply_value;
      IDX_THERMAL: read_word = thermal_value;
      IDX_DEVICE_INFO: read_word = device_info_value;
      IDX_WAKE_SOURCE: read_word = wake_source_value;
      IDX_WAKE_LEVEL: read_word = wake_level_value;
      IDX_GEN_BRIDGE: read_word = gen_bridge_value;
      IDX_DELAY_REG: read_word = delay_reg_value;
      IDX_DS_OV: read_word = ds_ov_value;
      IDX_EFF_DELAY1: read_word = eff_delay1_value;
      IDX_EFF_DELAY2: read_word = eff_delay2_value;
      IDX_EFF_DELAY3: read_word = eff_delay3_value;
      IDX_EDGE_TIME1: read_word = edge_time1_value;
      IDX_EDGE_TIME2: read_word = edge_time2_value;
      IDX_EDGE_TIME3: read_word = edge_time3_value;
      default: read_word = `WORD_ZERO;
    endcase
    if (is_id)
      read_word = FAMILY_ID; // R8
  end

  // Answer frame; CRC byte left for the link layer to fill
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      frame_out <= 32'h00000000;
      frame_out_valid <= 1'b0;
      addr_error <= 1'b0;
    end
    else
    begin
      frame_out_valid <= frame_valid;
      if (frame_valid)
      begin
        frame_out <= {8'h00, read_word, frame_in[`FRAME_MODE_BIT], addr}; // R4
        addr_error <= ~is_id & (idx == IDX_NONE);
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/stat_chk.sv
// Assertions on the status bank's frame answers.
// Bound to the bank; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module stat_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic soft_reset,
  input wire logic frame_valid,
  input wire logic [31:0] frame_in,
  input wire logic [31:0] frame_out,
  input wire logic frame_out_valid,
  input wire logic addr_error
);
  wire logic [6:0] a = frame_in[6:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Answer timing and fixed fields
  frame_answer_a: assert property (frame_valid |=> frame_out_valid) else $error("no answer");
  head_echo_a: assert property (frame_valid
    |=> frame_out[7:0] == $past(frame_in[7:0])) else $error("bad head");
  crc_byte_a: assert property (frame_out_valid |-> frame_out[31:24] == 8'h00) else $error("crc byte");
  reserved_bits_a: assert property (frame_valid && a == 7'h40
    |=> frame_out[22:21] == 2'b00) else $error("res bits");
  // Address map, clearing and power-on flag
  unmapped_addr_a: assert property (frame_valid && a[6:5] != 2'b10 && a != 7'h70
    |=> addr_error && frame_out[23:8] == 16'h0000) else $error("unmapped");
  word_clear_a: assert property (frame_valid && frame_in[7:0] == 8'hc0 ##2 frame_valid && a == 7'h40
    |=> !frame_out[23]) else $error("not cleared");
  soft_por_a: assert property (soft_reset && !frame_valid ##1 frame_valid && a == 7'h40
    |=> !frame_out[23]) else $error("soft por");
  power_on_a: assert property ($rose(rst_b) && !soft_reset && frame_valid && a == 7'h40
    |=> frame_out[23]) else $error("por lost");
  // Main scenarios
  cover property (frame_valid && frame_in[7]);
  cover property (frame_valid && a == 7'h70);
  cover property (soft_reset);
endmodule
bind spi_status_register_bank stat_chk chk (.*);
`default_nettype wire

// ### testbench/mcu_master.sv
// Microcontroller side: hands decoded status frames to the bank.
// Assumes frames are taken on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module mcu_master (
  input wire logic clk,
  output logic frame_valid,
  output logic [31:0] frame_in
);
  // Idle at start
  initial
    {frame_valid, frame_in} = 33'h000000000;
  // One frame after g+1 idle cycles; inverted once released
  task xfer(input logic [6:0] a, input logic m, input logic [23:0] j, input int g);
    repeat (g) @(posedge clk);
    @(posedge clk);
    #1;
    frame_in = {j, m, a};
    frame_valid = 1'b1;
    @(posedge clk);
    #1;
    frame_valid = 1'b0;
    frame_in = ~frame_in;
  endtask
endmodule
`default_nettype wire

// ### testbench/spi_status_register_bank_test.sv
// Frame traffic against the status bank, expected words kept per address.
// Needs the master model; the checker binds itself.
`timescale 1ns/1ps
`default_nettype none
module spi_status_register_bank_test;
  localparam logic [15:0] fam_id = 16'h3c07; // Arbitrary value
  logic clk = 1'b0;
  logic rst_b, soft_reset, reg_on, uvr, frame_valid, frame_out_valid, addr_error;
  logic [31:0] frame_in, frame_out, seed;
  logic [15:0] ev, x [0:127];
  logic [7:0] fl;
  int n_mismatch, n_compared;
  spi_status_register_bank #(.FAMILY_ID(fam_id)) uut (.main_regulator_output(reg_on), .pump_overtemp_flag(fl[7]),
    .regulator_uv_reset_event(uvr), .battery_undervoltage_flag(fl[6]), .battery_overvoltage_flag(fl[5]),
    .pump_undervoltage_flag(fl[4]), .regulator_short_flag(fl[3]), .regulator_undervoltage_flag(fl[2]),
    .regulator_overvoltage_flag(fl[1]), .regulator_prewarning_flag(fl[0]), .supply_other_events(ev),
    .thermal_events(ev), .device_info_events(ev), .wake_source_events(ev), .wake_level_events(ev),
    .gen_bridge_events(ev), .delay_reg_events(ev), .ds_ov_events(ev), .eff_delay1_events(ev),
    .eff_delay2_events(ev), .eff_delay3_events(ev), .edge_time1_events(ev), .edge_time2_events(ev),
    .edge_time3_events(ev), .*);
  mcu_master mm (.*);
  // Clock, 8 ns
  always #4 clk = ~clk;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic ok(input logic [6:0] a);
    return a inside {7'h40, 7'h41, 7'h42, 7'h44, 7'h45, [7'h50:7'h55], [7'h57:7'h59], 7'h70};
  endfunction
  task cmp(input logic [33:0] got, input logic [33:0] want);
    n_compared++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  task rd(input logic [6:0] a, input logic m, input int g);
    logic [15:0] w;
    w = x[a];
    seed = nxt(seed);
    mm.xfer(a, m, seed[23:0], g);
    cmp({frame_out_valid, addr_error, frame_out}, {1'b1, !ok(a), 8'h00, w, m, a});
    if (m && a != 7'h70) x[a] = 16'h0000;
  endtask
  task pulse(input logic on, input logic [7:0] f, input logic [15:0] e);
    @(posedge clk);
    #1;
    {reg_on, fl, ev} = {on, f, e};
    @(posedge clk);
    #1;
    {fl, ev} = 24'h000000;
    x[64] |= {3'b000, f[7], 1'b0, e[10:7], f[6:5] & {2{on}}, f[4:0]};
    for (int a = 65; a < 90; a++)
      if (ok(a[6:0])) x[a] |= e;
  endtask
  task report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial
  begin
    {rst_b, soft_reset, reg_on, uvr, fl, ev} = 28'h0000000;
    seed = 32'hd7bb;
    foreach (x[i])
      x[i] = 16'h0000;
    x[64] = 16'h8000;
    x[112] = fam_id;
    repeat (3) @(posedge clk);
    fork
      rd(7'h40, 1'b0, 0);
      begin
        @(posedge clk);
        #1;
        rst_b = 1'b1;
      end
    join
    rd(7'h40, 1'b1, 1);
    rd(7'h40, 1'b0, 0);
    $display("power-on test done");
    for (int p = 0; p < 4; p++)
    begin
      pulse(p[0], seed[15:8], seed[31:16]);
      for (int a = 0; a < 128; a++)
        rd(a[6:0], seed[3], seed[5:4]);
    end
    $display("sweep test done");
    foreach (x[i])
      x[i] = 16'h0000;
    x[112] = fam_id;
    reg_on = 1'b0;
    fork
      rd(7'h40, 1'b0, 0);
      begin
        soft_reset = 1'b1;
        @(posedge clk);
        #1;
        soft_reset = 1'b0;
      end
    join
    $display("soft reset test done");
    for (int i = 1; i < 5; i++)
    begin
      @(posedge clk);
      #1;
      uvr = 1'b1;
      @(posedge clk);
      #1;
      uvr = 1'b0;
      x[64] = {4'h0, i == 4, 11'h000};
      rd(7'h40, 1'b0, 0);
    end
    $display("fail-safe test done");
    fork
      rd(7'h40, 1'b1, 0);
      begin
        @(posedge clk);
        #1;
        fl = 8'h80;
        @(posedge clk);
        #1;
        fl = 8'h00;
      end
    join
    x[64] = 16'h1000;
    rd(7'h40, 1'b0, 0);
    $display("clear race test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
